/* flash_seq_host.sv */
// Purpose: host that issues flash command sequences on the parallel pins
// Assumes: one clock, synchronous active-high reset, flash pins in this clock
// Notes:   one request at a time; refused requests answer with RSP_ERR
// Notes on behaviour
// - byte mode unlock is AA@AAA, 55@555
// - third write A0 program, 20 bypass, 88 secured
// - erase: unlock, 80, unlock, 10 chip/30 sector
// - single F0 write resets; leaves autoselect
// - all cycles writes except plain and autoselect reads
// - autoselect: 90 at bank, then read offset
// - bypass program only inside bypass mode
// - only 90 then 00 leaves bypass
// - suspend B0 at bank, only during sector erase
// - resume 30 at bank, only when suspended
// - CFI 98@55 only when ready or autoselect
// - secured entry three writes, exit four writes
// - word mode unlock uses 555 and 2AA
`timescale 1ns/1ps
module flash_seq_host
	import flash_seq_pkg::*;
#(
	parameter int AW = 22
) (
	input  wire logic          CLK,
	input  wire logic          RESET,
	input  wire logic          CMD_VALID,
	output logic               CMD_READY,
	input  wire logic [4:0]    CMD_OP,
	input  wire logic [AW-1:0] CMD_ADDR,
	input  wire logic [15:0]   CMD_DATA,
	input  wire logic          BYTE_MODE,
	output logic               RSP_VALID,
	output logic               RSP_ERR,
	output logic [15:0]        RSP_DATA,
	output logic               BYPASS_ACTIVE,
	output logic               AUTOSEL_ACTIVE,
	output logic               SECURED_ACTIVE,
	output logic               ERASING,
	output logic               SUSPENDED,
	output logic [AW-1:0]      F_ADDR,
	output logic [15:0]        F_DQ_O,
	input  wire logic [15:0]   F_DQ_I,
	output logic               F_DQ_OE,
	output logic               F_CE_N,
	output logic               F_WE_N,
	output logic               F_OE_N
);
	// ==========================================================
	// state
	typedef struct packed {
		logic          rd;
		logic          last;
		logic [AW-1:0] a;
		logic [15:0]   d;
	} cyc_t;

	typedef struct packed {
		phase_t        phase;
		logic [2:0]    step;
		logic [7:0]    cnt;
		op_t           op;
		logic [AW-1:0] addr;
		logic [15:0]   data;
		logic          bm;
		logic          bypass;
		logic          autosel;
		logic          secured;
		logic          erasing;
		logic          suspended;
		logic          cfi;
		logic          rsp_valid;
		logic          rsp_err;
		logic [15:0]   rsp_data;
		logic [AW-1:0] f_addr;
		logic [15:0]   f_dq;
		logic          dq_oe;
		logic          ce_n;
		logic          we_n;
		logic          oe_n;
	} state_t;

	state_t st_reg;
	state_t st_next;
	cyc_t   cur;

	// ==========================================================
	// cycle table: address, data and direction of each step
	function automatic cyc_t cyc_of(op_t op, logic [2:0] s, logic bm, logic [AW-1:0] a, logic [15:0] d);
		cyc_t              c;
		logic [11:0]       u1;
		logic [11:0]       u2;
		logic [AW-1:0]     ca;
		logic [AW-1:0]     ba;
		logic              ul;
		u1 = bm ? UL1_BYTE : UL1_WORD;
		u2 = bm ? UL2_BYTE : UL2_WORD;
		// upper bits carry the bank; the flash ignores them on unlocks
		ba = {a[AW-1:CMD_LOW_BITS], 12'h000};
		ca = ba | AW'(u1);
		c = '{rd: 1'b0, last: 1'b0, a: '0, d: '0};
		ul = (s == 3'd0) || (s == 3'd1) ||
			((op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE) && (s == 3'd3 || s == 3'd4));
		if (ul) begin
			c.a = ba | AW'((s == 3'd0 || s == 3'd3) ? u1 : u2);
			c.d = {8'h00, (s == 3'd0 || s == 3'd3) ? CODE_UL1 : CODE_UL2};
		end
		unique case (op)
			OP_READ: begin
				c = '{rd: 1'b1, last: 1'b1, a: a, d: '0};
			end
			OP_RESET: begin
				c = '{rd: 1'b0, last: 1'b1, a: a, d: {8'h00, CODE_RESET}};
			end
			OP_SUSPEND: begin
				c = '{rd: 1'b0, last: 1'b1, a: a, d: {8'h00, CODE_SUSPEND}};
			end
			OP_RESUME: begin
				c = '{rd: 1'b0, last: 1'b1, a: a, d: {8'h00, CODE_RESUME}};
			end
			OP_CFI: begin
				c = '{rd: 1'b0, last: 1'b1, a: AW'(CFI_ADDR), d: {8'h00, CODE_CFI}};
			end
			OP_PROGRAM: begin
				if (s == 3'd2) begin
					c.a = ca;
					c.d = {8'h00, CODE_PROG};
				end else if (s == 3'd3) begin
					c = '{rd: 1'b0, last: 1'b1, a: a, d: d};
				end
			end
			OP_AS_MFR, OP_AS_DEV, OP_AS_LOCK, OP_AS_PROT: begin
				if (s == 3'd2) begin
					c.a = ca;
					c.d = {8'h00, CODE_AUTOSEL};
				end else if (s == 3'd3) begin
					c.rd = 1'b1;
					c.last = 1'b1;
					unique case (op)
						OP_AS_MFR:  c.a = ba | AW'(bm ? AS_MFR_BYTE : AS_MFR_WORD);
						OP_AS_DEV:  c.a = ba | AW'(bm ? AS_DEV_BYTE : AS_DEV_WORD);
						OP_AS_LOCK: c.a = ba | AW'(bm ? AS_LOCK_BYTE : AS_LOCK_WORD);
						default:    c.a = ba | AW'(bm ? AS_PROT_BYTE : AS_PROT_WORD);
					endcase
				end
			end
			OP_SEC_ENTER, OP_BYP_ENTER: begin
				if (s == 3'd2) begin
					c.a = ca;
					c.d = {8'h00, (op == OP_SEC_ENTER) ? CODE_SECURED : CODE_BYPASS};
					c.last = 1'b1;
				end
			end
			OP_SEC_EXIT: begin
				if (s == 3'd2) begin
					c.a = ca;
					c.d = {8'h00, CODE_AUTOSEL};
				end else if (s == 3'd3) begin
					c = '{rd: 1'b0, last: 1'b1, a: a, d: {8'h00, CODE_EXIT}};
				end
			end
			OP_BYP_PROG: begin
				c = '{rd: 1'b0, last: (s == 3'd1), a: a,
					d: (s == 3'd0) ? {8'h00, CODE_PROG} : d};
			end
			OP_BYP_EXIT: begin
				c = '{rd: 1'b0, last: (s == 3'd1), a: a,
					d: {8'h00, (s == 3'd0) ? CODE_AUTOSEL : CODE_EXIT}};
			end
			OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
				if (s == 3'd2) begin
					c.a = ca;
					c.d = {8'h00, CODE_ERASE};
				end else if (s == 3'd5) begin
					c.last = 1'b1;
					c.a = (op == OP_CHIP_ERASE) ? ca : a;
					c.d = {8'h00, (op == OP_CHIP_ERASE) ? CODE_CHIP : CODE_SECTOR};
				end
			end
		endcase
		return c;
	endfunction : cyc_of

	// ==========================================================
	// which requests the current mode allows
	function automatic logic allowed(op_t op, state_t r);
		logic ok;
		ok = 1'b1;
		if (r.bypass) begin
			// bypass mode is left only by its own two-write exit
			ok = (op == OP_READ) || (op == OP_BYP_PROG) || (op == OP_BYP_EXIT);
		end else begin
			unique case (op)
				OP_BYP_PROG, OP_BYP_EXIT: ok = 1'b0;
				OP_SUSPEND:               ok = r.erasing;
				OP_RESUME:                ok = r.suspended;
				OP_CFI:                   ok = r.autosel || (!r.erasing && !r.suspended && !r.cfi);
				OP_CHIP_ERASE, OP_SECTOR_ERASE: ok = !r.suspended && !r.autosel;
				default:                  ok = r.autosel ? (op == OP_READ || op == OP_RESET ||
					op == OP_AS_MFR || op == OP_AS_DEV || op == OP_AS_LOCK || op == OP_AS_PROT) : 1'b1;
			endcase
		end
		return ok;
	endfunction : allowed

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.rsp_valid = 1'b0;
		st_next.rsp_err = 1'b0;
		cur = cyc_of(st_reg.op, st_reg.step, st_reg.bm, st_reg.addr, st_reg.data);
		unique case (st_reg.phase)
			P_IDLE: begin
				if (CMD_VALID) begin
					st_next.op = op_t'(CMD_OP);
					st_next.addr = CMD_ADDR;
					st_next.data = CMD_DATA;
					st_next.bm = BYTE_MODE;
					st_next.step = 3'd0;
					// first setup edge only puts the pins out, full setup follows it
					st_next.cnt = AS_CYC;
					// refused requests never touch the pins, so no partial sequence is left
					// codes past the last op have no sequence behind them
					if (allowed(op_t'(CMD_OP), st_reg) && CMD_OP <= 5'(OP_CFI)) begin
						st_next.phase = P_SETUP;
					end else begin
						st_next.rsp_valid = 1'b1;
						st_next.rsp_err = 1'b1;
					end
				end
			end
			P_SETUP: begin
				st_next.f_addr = cur.a;
				st_next.f_dq = cur.d;
				st_next.dq_oe = !cur.rd;
				st_next.ce_n = 1'b0;
				if (st_reg.cnt != 8'd0) begin
					st_next.cnt = st_reg.cnt - 8'd1;
				end else if (cur.rd) begin
					st_next.phase = P_READ;
					st_next.oe_n = 1'b0;
					st_next.cnt = ACC_CYC - 8'd1;
				end else begin
					// address stable before WE falls; CE fell with the address
					st_next.phase = P_WPULSE;
					st_next.we_n = 1'b0;
					st_next.cnt = WP_CYC - 8'd1;
				end
			end
			P_WPULSE: begin
				if (st_reg.cnt != 8'd0) begin
					st_next.cnt = st_reg.cnt - 8'd1;
				end else begin
					// data still driven while both strobes rise together
					st_next.phase = P_WHOLD;
					st_next.we_n = 1'b1;
					st_next.ce_n = 1'b1;
					st_next.cnt = WPH_CYC - 8'd1;
				end
			end
			P_READ: begin
				if (st_reg.cnt != 8'd0) begin
					st_next.cnt = st_reg.cnt - 8'd1;
				end else begin
					st_next.rsp_data = F_DQ_I;
					st_next.oe_n = 1'b1;
					st_next.ce_n = 1'b1;
					st_next.phase = P_WHOLD;
					st_next.cnt = WPH_CYC - 8'd1;
				end
			end
			P_WHOLD: begin
				st_next.dq_oe = 1'b0;
				if (st_reg.cnt != 8'd0) begin
					st_next.cnt = st_reg.cnt - 8'd1;
				end else if (!cur.last) begin
					st_next.step = st_reg.step + 3'd1;
					st_next.phase = P_SETUP;
					st_next.cnt = AS_CYC;
				end else begin
					st_next.phase = P_IDLE;
					st_next.rsp_valid = 1'b1;
					unique case (st_reg.op)
						OP_RESET: begin
							st_next.autosel = 1'b0;
							st_next.cfi = 1'b0;
						end
						OP_AS_MFR, OP_AS_DEV, OP_AS_LOCK, OP_AS_PROT: st_next.autosel = 1'b1;
						OP_SEC_ENTER:    st_next.secured = 1'b1;
						OP_SEC_EXIT:     st_next.secured = 1'b0;
						OP_BYP_ENTER:    st_next.bypass = 1'b1;
						OP_BYP_EXIT:     st_next.bypass = 1'b0;
						OP_SECTOR_ERASE: st_next.erasing = 1'b1;
						OP_SUSPEND: begin
							st_next.erasing = 1'b0;
							st_next.suspended = 1'b1;
						end
						OP_RESUME: begin
							st_next.erasing = 1'b1;
							st_next.suspended = 1'b0;
						end
						OP_CFI:          st_next.cfi = 1'b1;
						default:         st_next.cfi = st_reg.cfi;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			st_reg <= '{phase: P_IDLE, op: OP_READ, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs
	assign CMD_READY      = (st_reg.phase == P_IDLE);
	assign RSP_VALID      = st_reg.rsp_valid;
	assign RSP_ERR        = st_reg.rsp_err;
	assign RSP_DATA       = st_reg.rsp_data;
	assign BYPASS_ACTIVE  = st_reg.bypass;
	assign AUTOSEL_ACTIVE = st_reg.autosel;
	assign SECURED_ACTIVE = st_reg.secured;
	assign ERASING        = st_reg.erasing;
	assign SUSPENDED      = st_reg.suspended;
	assign F_ADDR         = st_reg.f_addr;
	assign F_DQ_O         = st_reg.f_dq;
	assign F_DQ_OE        = st_reg.dq_oe;
	assign F_CE_N         = st_reg.ce_n;
	assign F_WE_N         = st_reg.we_n;
	assign F_OE_N         = st_reg.oe_n;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	logic unlocked_op;
	assign unlocked_op = !(st_reg.op inside {OP_READ, OP_RESET, OP_SUSPEND, OP_RESUME, OP_CFI,
		OP_BYP_PROG, OP_BYP_EXIT});

	unlock_first_a: assert property ($fell(F_WE_N) && unlocked_op && st_reg.step == 3'd0 |->
		F_DQ_O[7:0] == CODE_UL1 && F_ADDR[11:0] == (st_reg.bm ? UL1_BYTE : UL1_WORD))
		else $error("first unlock write wrong");
	unlock_second_a: assert property ($fell(F_WE_N) && unlocked_op && st_reg.step == 3'd1 |->
		F_DQ_O[7:0] == CODE_UL2 && F_ADDR[11:0] == (st_reg.bm ? UL2_BYTE : UL2_WORD))
		else $error("second unlock write wrong");
	program_code_a: assert property ($fell(F_WE_N) && st_reg.op == OP_PROGRAM && st_reg.step == 3'd2 |->
		F_DQ_O[7:0] == CODE_PROG) else $error("program code not A0");
	erase_final_a: assert property ($fell(F_WE_N) && st_reg.op == OP_CHIP_ERASE && st_reg.step == 3'd5 |->
		F_DQ_O[7:0] == CODE_CHIP && $past(st_reg.step, 1) == 3'd5) else $error("chip erase last write wrong");
	reset_write_a: assert property ($fell(F_WE_N) && st_reg.op == OP_RESET |->
		F_DQ_O[7:0] == CODE_RESET ##[1:20] (RSP_VALID && !AUTOSEL_ACTIVE)) else $error("reset write or exit wrong");
	read_cycle_a: assert property (!F_OE_N |-> F_WE_N && !F_DQ_OE && !F_CE_N)
		else $error("read cycle drives bus");
	autosel_read_a: assert property (st_reg.op == OP_AS_PROT && st_reg.step == 3'd3 && st_reg.phase == P_READ
		|-> F_ADDR[11:0] == (st_reg.bm ? AS_PROT_BYTE : AS_PROT_WORD)) else $error("autoselect read offset wrong");
	bypass_gate_a: assert property ($fell(F_WE_N) && st_reg.op == OP_BYP_PROG |-> BYPASS_ACTIVE)
		else $error("bypass program outside bypass");
	bypass_exit_a: assert property (RSP_VALID && !RSP_ERR && st_reg.op == OP_BYP_EXIT |-> !BYPASS_ACTIVE)
		else $error("bypass not left");
	bypass_hold_a: assert property (BYPASS_ACTIVE && CMD_READY && CMD_VALID && CMD_OP == 5'(OP_RESET)
		|=> RSP_VALID && RSP_ERR) else $error("reset accepted in bypass");
	suspend_gate_a: assert property ($fell(F_WE_N) && st_reg.op == OP_SUSPEND |-> ERASING)
		else $error("suspend without sector erase");
	resume_gate_a: assert property ($fell(F_WE_N) && st_reg.op == OP_RESUME |-> SUSPENDED)
		else $error("resume while not suspended");
	cfi_gate_a: assert property ($fell(F_WE_N) && st_reg.op == OP_CFI |->
		F_DQ_O[7:0] == CODE_CFI && !BYPASS_ACTIVE && !SUSPENDED) else $error("cfi write wrong");
	secured_exit_a: assert property ($fell(F_WE_N) && st_reg.op == OP_SEC_EXIT && st_reg.step == 3'd3 |->
		F_DQ_O[7:0] == CODE_EXIT) else $error("secured exit write wrong");

	program_c: cover property (RSP_VALID && !RSP_ERR && st_reg.op == OP_PROGRAM);
	erase_suspend_c: cover property (SUSPENDED && RSP_VALID && st_reg.op == OP_SUSPEND);
	autosel_c: cover property (RSP_VALID && st_reg.op == OP_AS_DEV);
	refused_c: cover property (RSP_VALID && RSP_ERR);
endmodule : flash_seq_host

/* flash_seq_pkg.sv */
// Purpose: constants and types for the flash command sequence host
// Assumes: 200 MHz clock, parallel NOR flash with byte and word modes
// Notes:   command codes, unlock addresses, autoselect offsets, bus timing
package flash_seq_pkg;
	// ==========================================================
	// command codes on the low data byte
	localparam logic [7:0]  CODE_UL1      = 8'haa;
	localparam logic [7:0]  CODE_UL2      = 8'h55;
	localparam logic [7:0]  CODE_PROG     = 8'ha0;
	localparam logic [7:0]  CODE_BYPASS   = 8'h20;
	localparam logic [7:0]  CODE_SECURED  = 8'h88;
	localparam logic [7:0]  CODE_ERASE    = 8'h80;
	localparam logic [7:0]  CODE_CHIP     = 8'h10;
	localparam logic [7:0]  CODE_SECTOR   = 8'h30;
	localparam logic [7:0]  CODE_RESET    = 8'hf0;
	localparam logic [7:0]  CODE_AUTOSEL  = 8'h90;
	localparam logic [7:0]  CODE_EXIT     = 8'h00;
	localparam logic [7:0]  CODE_SUSPEND  = 8'hb0;
	localparam logic [7:0]  CODE_RESUME   = 8'h30;
	localparam logic [7:0]  CODE_CFI      = 8'h98;
	// ==========================================================
	// low address bits of command cycles, byte and word mode
	localparam logic [11:0] UL1_BYTE      = 12'haaa;
	localparam logic [11:0] UL2_BYTE      = 12'h555;
	localparam logic [11:0] UL1_WORD      = 12'h555;
	localparam logic [11:0] UL2_WORD      = 12'h2aa;
	localparam logic [11:0] CFI_ADDR      = 12'h055;
	localparam logic [11:0] AS_MFR_BYTE   = 12'h000;
	localparam logic [11:0] AS_DEV_BYTE   = 12'h002;
	localparam logic [11:0] AS_LOCK_BYTE  = 12'h006;
	localparam logic [11:0] AS_PROT_BYTE  = 12'h004;
	localparam logic [11:0] AS_MFR_WORD   = 12'h000;
	localparam logic [11:0] AS_DEV_WORD   = 12'h001;
	localparam logic [11:0] AS_LOCK_WORD  = 12'h003;
	localparam logic [11:0] AS_PROT_WORD  = 12'h002;
	localparam int          CMD_LOW_BITS  = 12;
	// ==========================================================
	// bus timing
	localparam int          CLK_MHZ       = 200;
	localparam int          T_AS_NS       = 10;
	localparam int          T_WP_NS       = 35;
	localparam int          T_WPH_NS      = 20;
	localparam int          T_ACC_NS      = 70;
	localparam logic [7:0]  AS_CYC        = 8'((T_AS_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  WP_CYC        = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  WPH_CYC       = 8'((T_WPH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  ACC_CYC       = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
	// ==========================================================
	typedef enum logic [4:0] {
		OP_READ, OP_RESET, OP_AS_MFR, OP_AS_DEV, OP_AS_LOCK, OP_AS_PROT,
		OP_SEC_ENTER, OP_SEC_EXIT, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROG,
		OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_CFI
	} op_t;
	typedef enum logic [2:0] {P_IDLE, P_SETUP, P_WPULSE, P_WHOLD, P_READ} phase_t;
endpackage : flash_seq_pkg

/* flash_dev_model.sv */
// Purpose: behavioural flash part on the far side of the host
// Assumes: host strobes are clean, one write cycle at a time
// Notes:   logs every write for the bench; ids are arbitrary
`timescale 1ns/1ps
module flash_dev_model
	import flash_seq_pkg::*;
#(
	parameter logic [7:0] MFR_ID = 8'h3c, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h6b  // arbitrary value
) (
	input  wire logic [21:0] F_ADDR,
	input  wire logic [15:0] F_DQ_O,
	input  wire logic        F_CE_N,
	input  wire logic        F_WE_N,
	input  wire logic        F_OE_N,
	input  wire logic        BYTE_MODE,
	output logic      [15:0] F_DQ_I
);
	logic [21:0] wa [0:255];
	logic [15:0] wd [0:255];
	int          nw = 0;
	logic [21:0] la = '0;
	logic [19:0] h1 = '0;
	logic [19:0] h2 = '0;
	logic        asel = 1'b0;
	logic [15:0] last = 16'h0000;
	wire         strobe_n = F_WE_N | F_CE_N;
	int          nf = 0;
	// ==========================================================
	// write cycles
	always @(negedge strobe_n) begin
		la = F_ADDR;
		nf++;
	end
	// strobes leaving x at power-up have no fall before them: no write
	always @(posedge strobe_n) if (nf > nw) begin
		wa[nw % 256] = la;
		wd[nw % 256] = F_DQ_O;
		nw++;
		// low byte and low address only: upper bits are don't care
		if (F_DQ_O[7:0] == CODE_RESET) asel = 1'b0;
		else if (F_DQ_O[7:0] == CODE_EXIT && h1[7:0] == CODE_AUTOSEL) asel = 1'b0;
		else if (F_DQ_O[7:0] == CODE_AUTOSEL && h2 == {BYTE_MODE ? UL1_BYTE : UL1_WORD, CODE_UL1}
			&& h1 == {BYTE_MODE ? UL2_BYTE : UL2_WORD, CODE_UL2}) asel = 1'b1;
		h2 = h1;
		h1 = {la[11:0], F_DQ_O[7:0]};
	end
	// ==========================================================
	// read cycles
	function automatic logic [7:0] id_byte(input logic [11:0] o, input logic s);
		if (o == (BYTE_MODE ? AS_MFR_BYTE : AS_MFR_WORD)) return MFR_ID;
		if (o == (BYTE_MODE ? AS_DEV_BYTE : AS_DEV_WORD)) return DEV_ID;
		if (o == (BYTE_MODE ? AS_LOCK_BYTE : AS_LOCK_WORD)) return 8'h82;
		if (o == (BYTE_MODE ? AS_PROT_BYTE : AS_PROT_WORD)) return {7'h00, s};
		return 8'hff;
	endfunction : id_byte
	// released bus shows the inverse, so a late sample cannot match by luck
	always @(F_CE_N, F_OE_N, F_ADDR, asel) begin
		if (!F_CE_N && !F_OE_N) begin
			last = asel ? {8'h00, id_byte(F_ADDR[11:0], F_ADDR[12])} : F_ADDR[15:0] ^ 16'ha5c3;
			F_DQ_I = last;
		end else F_DQ_I = ~last;
	end
endmodule : flash_dev_model

/* flash_command_sequence_decoder_tb.sv */
// Purpose: self-checking bench for the flash command host
// Assumes: 200 MHz clock, device model on the flash pins
// Notes:   one task per scenario; the model's write log is compared
`timescale 1ns/1ps
module flash_command_sequence_decoder_tb;
	import flash_seq_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        byte_mode = 1'b1;
	logic [4:0]  cmd_op = 5'h00;
	logic [21:0] cmd_addr = 22'h000000;
	logic [15:0] cmd_data = 16'h0000;
	logic        cmd_ready, rsp_valid, rsp_err, byp, asel, sec, ers, susp;
	logic        dq_oe, ce_n, we_n, oe_n;
	logic [15:0] rsp_data, dq_o, dq_i;
	logic [21:0] f_addr;
	logic [21:0] qa [$];
	logic [15:0] qd [$];
	int          checked = 0;
	int          miscompares = 0;
	int          cycles = 0;
	flash_seq_host #(.AW(22)) DUT (
		.CLK(clk), .RESET(reset), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
		.CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .BYTE_MODE(byte_mode), .RSP_VALID(rsp_valid),
		.RSP_ERR(rsp_err), .RSP_DATA(rsp_data), .BYPASS_ACTIVE(byp), .AUTOSEL_ACTIVE(asel),
		.SECURED_ACTIVE(sec), .ERASING(ers), .SUSPENDED(susp), .F_ADDR(f_addr), .F_DQ_O(dq_o),
		.F_DQ_I(dq_i), .F_DQ_OE(dq_oe), .F_CE_N(ce_n), .F_WE_N(we_n), .F_OE_N(oe_n));
	flash_dev_model mdl (.F_ADDR(f_addr), .F_DQ_O(dq_o), .F_CE_N(ce_n), .F_WE_N(we_n),
		.F_OE_N(oe_n), .BYTE_MODE(byte_mode), .F_DQ_I(dq_i));
	initial forever #2.5 clk = ~clk;
	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : check
	task automatic results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	function automatic logic [21:0] ca(input logic [21:0] a);
		return {a[21:12], byte_mode ? UL1_BYTE : UL1_WORD};
	endfunction : ca
	task automatic ew(input logic [21:0] a, input logic [15:0] d);
		qa.push_back(a);
		qd.push_back(d);
	endtask : ew
	task automatic ul(input logic [21:0] a);
		ew(ca(a), 16'(CODE_UL1));
		ew({a[21:12], byte_mode ? UL2_BYTE : UL2_WORD}, 16'(CODE_UL2));
	endtask : ul
	// one request, then the pin writes are checked against the queue
	task automatic run(input op_t op, input logic [21:0] a, input logic [15:0] d, input logic err);
		int n;
		int base;
		int exp_n;
		n = 0;
		base = mdl.nw;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 300);
		check({rsp_valid, rsp_err}, {1'b1, err}, "response flags");
		// each bus cycle: setup entry, setup, strobe or access, hold
		exp_n = qa.size() * (1 + AS_CYC + WP_CYC + WPH_CYC) + 1;
		if (op inside {OP_READ, OP_AS_MFR, OP_AS_DEV, OP_AS_LOCK, OP_AS_PROT}) begin
			exp_n += 1 + AS_CYC + ACC_CYC + WPH_CYC;
		end
		check(n, err ? 1 : exp_n, "response delay");
		@(posedge clk);
		check(mdl.nw - base, qa.size(), "write count");
		foreach (qa[i]) begin
			check(mdl.wa[(base + i) % 256], qa[i], "write address");
			check(mdl.wd[(base + i) % 256], qd[i], "write data");
		end
		qa.delete();
		qd.delete();
	endtask : run
	// ==========================================================
	// scenarios
	task automatic t_reset();
		check({cmd_ready, ce_n, we_n, oe_n, dq_oe}, 5'b11110, "idle pins");
		check({byp, asel, sec, ers, susp}, 5'b00000, "idle modes");
		$display("test reset done");
	endtask : t_reset
	task automatic t_prog();
		for (int b = 0; b < 2; b++) begin
			byte_mode <= b[0];
			@(posedge clk);
			run(OP_READ, 22'h2b1234, 16'h0000, 1'b0);
			check(rsp_data, 16'h1234 ^ 16'ha5c3, "array read");
			ul(22'h3c5a7e);
			ew(ca(22'h3c5a7e), 16'(CODE_PROG));
			ew(22'h3c5a7e, 16'hbeef);
			run(OP_PROGRAM, 22'h3c5a7e, 16'hbeef, 1'b0);
		end
		$display("test program done");
	endtask : t_prog
	task automatic t_asel();
		op_t        ops [4];
		logic [7:0] ids [4];
		ops = '{OP_AS_MFR, OP_AS_DEV, OP_AS_LOCK, OP_AS_PROT};
		ids = '{mdl.MFR_ID, mdl.DEV_ID, 8'h82, 8'h01};
		for (int i = 0; i < 4; i++) begin
			ul(22'h1f3000);
			ew(ca(22'h1f3000), 16'(CODE_AUTOSEL));
			run(ops[i], 22'h1f3000, 16'h0000, 1'b0);
			check(rsp_data[7:0], ids[i], "autoselect id");
			check(asel, 1'b1, "autoselect mode");
		end
		run(OP_PROGRAM, 22'h1f3000, 16'h1111, 1'b1);
		ew(22'h000055, 16'(CODE_CFI));
		run(OP_CFI, 22'h1f3000, 16'h0000, 1'b0);
		ew(22'h1f3000, 16'(CODE_RESET));
		run(OP_RESET, 22'h1f3000, 16'h0000, 1'b0);
		check(asel, 1'b0, "autoselect left");
		run(OP_READ, 22'h1f3000, 16'h0000, 1'b0);
		check(rsp_data, 16'h3000 ^ 16'ha5c3, "read after reset");
		$display("test autoselect done");
	endtask : t_asel
	task automatic t_byp();
		run(OP_BYP_PROG, 22'h004000, 16'h2222, 1'b1);
		run(OP_BYP_EXIT, 22'h004000, 16'h0000, 1'b1);
		ul(22'h004000);
		ew(ca(22'h004000), 16'(CODE_BYPASS));
		run(OP_BYP_ENTER, 22'h004000, 16'h0000, 1'b0);
		check(byp, 1'b1, "bypass entered");
		ew(22'h004abc, 16'(CODE_PROG));
		ew(22'h004abc, 16'h2222);
		run(OP_BYP_PROG, 22'h004abc, 16'h2222, 1'b0);
		run(OP_PROGRAM, 22'h004abc, 16'h3333, 1'b1);
		run(OP_RESET, 22'h004abc, 16'h0000, 1'b1);
		check(byp, 1'b1, "bypass kept");
		ew(22'h004000, 16'(CODE_AUTOSEL));
		ew(22'h004000, 16'(CODE_EXIT));
		run(OP_BYP_EXIT, 22'h004000, 16'h0000, 1'b0);
		check(byp, 1'b0, "bypass left");
		$display("test bypass done");
	endtask : t_byp
	task automatic t_sec();
		ul(22'h000000);
		ew(ca(22'h000000), 16'(CODE_SECURED));
		run(OP_SEC_ENTER, 22'h000000, 16'h0000, 1'b0);
		check(sec, 1'b1, "secured entered");
		ul(22'h000000);
		ew(ca(22'h000000), 16'(CODE_AUTOSEL));
		ew(22'h000000, 16'(CODE_EXIT));
		run(OP_SEC_EXIT, 22'h000000, 16'h0000, 1'b0);
		check(sec, 1'b0, "secured left");
		$display("test secured done");
	endtask : t_sec
	task automatic t_erase();
		run(op_t'(5'h1f), 22'h2a6000, 16'h0000, 1'b1);
		run(OP_SUSPEND, 22'h2a6000, 16'h0000, 1'b1);
		run(OP_RESUME, 22'h2a6000, 16'h0000, 1'b1);
		for (int k = 0; k < 2; k++) begin
			ul(22'h2a6000);
			ew(ca(22'h2a6000), 16'(CODE_ERASE));
			ul(22'h2a6000);
			if (k == 0) ew(ca(22'h2a6000), 16'(CODE_CHIP));
			else ew(22'h2a6000, 16'(CODE_SECTOR));
			run(k == 0 ? OP_CHIP_ERASE : OP_SECTOR_ERASE, 22'h2a6000, 16'h0000, 1'b0);
			check(ers, k[0], "erasing level");
		end
		run(OP_CFI, 22'h2a6000, 16'h0000, 1'b1);
		ew(22'h2a6000, 16'(CODE_SUSPEND));
		run(OP_SUSPEND, 22'h2a6000, 16'h0000, 1'b0);
		check({ers, susp}, 2'b01, "suspended");
		ul(22'h0a1000);
		ew(ca(22'h0a1000), 16'(CODE_PROG));
		ew(22'h0a1234, 16'h4455);
		run(OP_PROGRAM, 22'h0a1234, 16'h4455, 1'b0);
		run(OP_SECTOR_ERASE, 22'h2a6000, 16'h0000, 1'b1);
		ew(22'h2a6000, 16'(CODE_RESUME));
		run(OP_RESUME, 22'h2a6000, 16'h0000, 1'b0);
		check({ers, susp}, 2'b10, "resumed");
		run(OP_RESUME, 22'h2a6000, 16'h0000, 1'b1);
		$display("test erase done");
	endtask : t_erase
	// ==========================================================
	// run limit: whole sequence needs well under 6000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_prog();
		t_asel();
		t_byp();
		t_sec();
		t_erase();
		// reset in mid-run while erasing: every mode flag must drop
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		results();
	end
endmodule : flash_command_sequence_decoder_tb
